/* File: hdl/tqs_sched_top.sv */
// transmit queue ratio registers and egress schedulers for ports 2 and 3
//
// Contract
// - queue 3 strict: drain it before lower queues
// - queue 3 ratio: low-field count per period
// - queue 2 strict: drain before lower queues
// - queue 2 ratio: high-field count per period
// - queue 1 strict: send before queue 0
// - queue 0 strict: served only after higher queues
// - queues 0/1 ratio: capped by their fields
// - reset ratios: queue 3 0x08, queue 2 0x04
// - reset ratios: queue 1 0x02, queue 0 0x01
// - all control bits reset to ratio mode
// - each port: two independent 16-bit RW registers
`timescale 1ns/10ps
module tqs_sched_top
  import tqs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_be,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [1:0][3:0] q_pending,
  input wire logic [1:0] take,
  output logic [1:0] sel_valid,
  output logic [1:0][1:0] sel_queue
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  // cfg[0]/cfg[1] are port 2 high/low, cfg[2]/cfg[3] port 3 high/low
  typedef struct packed {
    logic [3:0][15:0] cfg;
    logic [15:0] rdata;
    logic [10:0] period_cnt;
    logic period_tick;
  } tqs_main_s;

  tqs_main_s r;
  tqs_main_s next_r;
  logic hit;
  logic [1:0] hit_idx;

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  // bit 0 is ignored so an 8-bit host reaches the upper byte with be[1]
  always_comb begin
    hit = 1'b1;
    hit_idx = 2'h0;
    case ({reg_addr[11:1], 1'b0})
      TQS_P2_HI_OFS: begin
        hit_idx = 2'h0;
      end
      TQS_P2_LO_OFS: begin
        hit_idx = 2'h1;
      end
      TQS_P3_HI_OFS: begin
        hit_idx = 2'h2;
      end
      TQS_P3_LO_OFS: begin
        hit_idx = 2'h3;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_r = r;
    if (reg_wr && hit) begin
      if (reg_be[0]) begin
        next_r.cfg[hit_idx][7:0] = reg_wdata[7:0];
      end
      if (reg_be[1]) begin
        next_r.cfg[hit_idx][15:8] = reg_wdata[15:8];
      end
    end
    // unmapped reads answer zero; the word holds until the next read
    if (reg_rd) begin
      next_r.rdata = hit ? r.cfg[hit_idx] : 16'h0000;
    end
    // free-running period so every port sees the same boundary
    if (r.period_cnt == TQS_PCNT_LAST) begin
      next_r.period_cnt = 11'h000;
      next_r.period_tick = 1'b1;
    end else begin
      next_r.period_cnt = r.period_cnt + 11'h001;
      next_r.period_tick = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r.cfg[0] <= TQS_HI_RST;
      r.cfg[1] <= TQS_LO_RST;
      r.cfg[2] <= TQS_HI_RST;
      r.cfg[3] <= TQS_LO_RST;
      r.rdata <= 16'h0000;
      r.period_cnt <= 11'h000;
      r.period_tick <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata = r.rdata;

  // ------------------------------------------------------------------
  // per-port schedulers
  // ------------------------------------------------------------------
  tqs_sched_if sif [TQS_NUM_PORTS] ();

  for (genvar p = 0; p < TQS_NUM_PORTS; p++) begin : g_port
    assign sif[p].hi_cfg = r.cfg[2 * p];
    assign sif[p].lo_cfg = r.cfg[2 * p + 1];
    assign sif[p].period_tick = r.period_tick;
    assign sif[p].q_pending = q_pending[p];
    assign sif[p].take = take[p];
    assign sel_valid[p] = sif[p].sel_valid;
    assign sel_queue[p] = sif[p].sel_queue;

    tqs_port_sched u_sched (
      .clk(clk),
      .reset_n(reset_n),
      .sif(sif[p])
    );
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // high in the first cycle after reset is released
  logic rst_seen;
  always_ff @(posedge clk) begin
    rst_seen <= !reset_n;
  end

  sequence s_full_write(logic [11:0] ofs);
    reg_wr && reg_be == 2'h3 && {reg_addr[11:1], 1'b0} == ofs;
  endsequence

  a_hi_reset_ratio: assert property (
    rst_seen && !reg_wr |-> r.cfg[0][6:0] == 7'h08 && r.cfg[0][14:8] == 7'h04
      && r.cfg[2][6:0] == 7'h08 && r.cfg[2][14:8] == 7'h04)
    else $error("high register ratios wrong after reset");
  a_lo_reset_ratio: assert property (
    rst_seen && !reg_wr |-> r.cfg[1][6:0] == 7'h02 && r.cfg[1][14:8] == 7'h01
      && r.cfg[3][6:0] == 7'h02 && r.cfg[3][14:8] == 7'h01)
    else $error("low register ratios wrong after reset");
  a_ctrl_reset_mode: assert property (
    rst_seen && !reg_wr |-> r.cfg[0][15] && r.cfg[0][7] && r.cfg[1][15] && r.cfg[1][7]
      && r.cfg[2][15] && r.cfg[2][7] && r.cfg[3][15] && r.cfg[3][7])
    else $error("control bits not in ratio mode after reset");
  a_p3_lo_write: assert property (
    s_full_write(TQS_P3_LO_OFS) |=> r.cfg[3] == $past(reg_wdata)
      && $stable(r.cfg[2]) && $stable(r.cfg[0]) && $stable(r.cfg[1]))
    else $error("port 3 low register write not isolated");
  a_p2_hi_write: assert property (
    s_full_write(TQS_P2_HI_OFS) ##1 reg_rd && !reg_wr && reg_addr == TQS_P2_HI_OFS
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("port 2 high register does not read back");
  a_byte_lane_keep: assert property (
    reg_wr && reg_be == 2'h1 && {reg_addr[11:1], 1'b0} == TQS_P2_LO_OFS
      |=> r.cfg[1][15:8] == $past(r.cfg[1][15:8]) && r.cfg[1][7:0] == $past(reg_wdata[7:0]))
    else $error("byte enable not honoured");
  a_unmapped_read: assert property (
    reg_rd && !hit |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_period_spacing: assert property (
    r.period_tick |=> !r.period_tick [*8])
    else $error("period boundary too frequent");
  a_period_count: assert property (
    r.period_cnt == TQS_PCNT_LAST |=> r.period_tick && r.period_cnt == 11'h000)
    else $error("period boundary not at last count");

endmodule

/* File: pkg/tqs_pkg.sv */
// constants and types shared by the transmit queue ratio scheduler
package tqs_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses on the host interface)
  // ------------------------------------------------------------------
  localparam logic [11:0] TQS_P2_HI_OFS = 12'h0cc;
  localparam logic [11:0] TQS_P2_LO_OFS = 12'h0ce;
  localparam logic [11:0] TQS_P3_HI_OFS = 12'h0d0;
  localparam logic [11:0] TQS_P3_LO_OFS = 12'h0d2;

  // ------------------------------------------------------------------
  // field layout, same in the high and the low register of a pair
  // ------------------------------------------------------------------
  localparam int TQS_LOW_CTRL_BIT = 7;
  localparam int TQS_LOW_RATIO_LSB = 0;
  localparam int TQS_HIGH_CTRL_BIT = 15;
  localparam int TQS_HIGH_RATIO_LSB = 8;
  localparam int TQS_RATIO_W = 7;
  localparam int TQS_NUM_PORTS = 2;
  localparam int TQS_NUM_Q = 4;
  localparam int TQS_NUM_REGS = 4;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [6:0] TQS_Q3_RATIO_RST = 7'h08;
  localparam logic [6:0] TQS_Q2_RATIO_RST = 7'h04;
  localparam logic [6:0] TQS_Q1_RATIO_RST = 7'h02;
  localparam logic [6:0] TQS_Q0_RATIO_RST = 7'h01;
  localparam logic TQS_CTRL_RST = 1'b1;
  localparam logic [15:0] TQS_HI_RST = {TQS_CTRL_RST, TQS_Q2_RATIO_RST,
                                        TQS_CTRL_RST, TQS_Q3_RATIO_RST};
  localparam logic [15:0] TQS_LO_RST = {TQS_CTRL_RST, TQS_Q0_RATIO_RST,
                                        TQS_CTRL_RST, TQS_Q1_RATIO_RST};
  localparam logic [3:0][6:0] TQS_ALLOW_RST = {TQS_Q3_RATIO_RST, TQS_Q2_RATIO_RST,
                                               TQS_Q1_RATIO_RST, TQS_Q0_RATIO_RST};

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int TQS_CLK_PERIOD_PS = 5000;
  localparam int TQS_SCHED_PERIOD_US = 10;
  localparam int TQS_PERIOD_CYC = (TQS_SCHED_PERIOD_US * 1000000) / TQS_CLK_PERIOD_PS;
  localparam int TQS_PCNT_W = 11;
  localparam logic [10:0] TQS_PCNT_LAST = 11'(TQS_PERIOD_CYC - 1);

  typedef enum logic {TQS_RUN, TQS_HOLD} tqs_sched_e;

endpackage

/* File: pkg/tqs_sched_if.sv */
// signals between the register side and one port's queue scheduler
`timescale 1ns/10ps
interface tqs_sched_if;
  logic [15:0] hi_cfg;
  logic [15:0] lo_cfg;
  logic period_tick;
  logic [3:0] q_pending;
  logic take;
  logic sel_valid;
  logic [1:0] sel_queue;

  modport ctrl (
    output hi_cfg,
    output lo_cfg,
    output period_tick,
    output q_pending,
    output take,
    input sel_valid,
    input sel_queue
  );

  modport sched (
    input hi_cfg,
    input lo_cfg,
    input period_tick,
    input q_pending,
    input take,
    output sel_valid,
    output sel_queue
  );
endinterface

/* File: hdl/tqs_port_sched.sv */
// per-port four-queue strict/ratio egress selector
`timescale 1ns/10ps
module tqs_port_sched
  import tqs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  tqs_sched_if.sched sif
);

  typedef struct packed {
    logic [3:0][6:0] allow;
    logic sel_valid;
    logic [1:0] sel_queue;
    tqs_sched_e st;
  } tqs_port_s;

  tqs_port_s r;
  tqs_port_s next_r;
  logic [3:0] ratio_on;
  logic [3:0][6:0] ratio_val;
  logic [3:0] eligible;

  // index 3 is the highest priority queue
  assign ratio_on = {sif.hi_cfg[TQS_LOW_CTRL_BIT], sif.hi_cfg[TQS_HIGH_CTRL_BIT],
                     sif.lo_cfg[TQS_LOW_CTRL_BIT], sif.lo_cfg[TQS_HIGH_CTRL_BIT]};
  assign ratio_val = {sif.hi_cfg[TQS_LOW_RATIO_LSB +: TQS_RATIO_W],
                      sif.hi_cfg[TQS_HIGH_RATIO_LSB +: TQS_RATIO_W],
                      sif.lo_cfg[TQS_LOW_RATIO_LSB +: TQS_RATIO_W],
                      sif.lo_cfg[TQS_HIGH_RATIO_LSB +: TQS_RATIO_W]};

  always_comb begin
    next_r = r;
    if (sif.period_tick) begin
      next_r.allow = ratio_val;
    end
    // a take in the tick cycle is charged to the fresh period
    if (sif.take && r.sel_valid && ratio_on[r.sel_queue]) begin
      if (next_r.allow[r.sel_queue] != 7'h00) begin
        next_r.allow[r.sel_queue] = next_r.allow[r.sel_queue] - 7'h01;
      end
    end
    for (int q = 0; q < TQS_NUM_Q; q++) begin
      // strict queues are eligible whenever pending, ratio queues only when pending with allowance left
      eligible[q] = sif.q_pending[q] && (!ratio_on[q] || next_r.allow[q] != 7'h00);
    end
    next_r.sel_queue = r.sel_queue;
    for (int q = 0; q < TQS_NUM_Q; q++) begin
      if (eligible[q]) begin
        next_r.sel_queue = 2'(q);
      end
    end
    next_r.sel_valid = |eligible;
    case (r.st)
      TQS_RUN: begin
        if (|sif.q_pending && !(|eligible)) begin
          next_r.st = TQS_HOLD;
        end
      end
      TQS_HOLD: begin
        if (|eligible || !(|sif.q_pending)) begin
          next_r.st = TQS_RUN;
        end
      end
      default: begin
        next_r.st = TQS_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r.allow <= TQS_ALLOW_RST;
      r.sel_valid <= 1'b0;
      r.sel_queue <= 2'h0;
      r.st <= TQS_RUN;
    end else begin
      r <= next_r;
    end
  end

  assign sif.sel_valid = r.sel_valid;
  assign sif.sel_queue = r.sel_queue;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_q3_last_take;
    r.sel_valid && r.sel_queue == 2'h3 && sif.take && ratio_on[3]
      && r.allow[3] == 7'h01 && !sif.period_tick;
  endsequence

  sequence s_q3_blocked;
    !(r.sel_valid && r.sel_queue == 2'h3);
  endsequence

  a_q3_strict_first: assert property (
    sif.q_pending[3] && !ratio_on[3] |=> r.sel_valid && r.sel_queue == 2'h3)
    else $error("strict queue 3 not selected");
  a_q3_ratio_cap: assert property (
    s_q3_last_take ##1 !sif.period_tick |=> s_q3_blocked)
    else $error("queue 3 sent beyond its ratio");
  a_q2_strict_drain: assert property (
    sif.q_pending[2] && !ratio_on[2] && !sif.q_pending[3] |=> r.sel_queue == 2'h2)
    else $error("strict queue 2 not drained first");
  a_q2_ratio_cap: assert property (
    ratio_on[2] && r.allow[2] == 7'h00 && !sif.period_tick
      |=> !(r.sel_valid && r.sel_queue == 2'h2))
    else $error("queue 2 sent with no allowance");
  a_q1_strict_first: assert property (
    sif.q_pending[1] && !ratio_on[1] && sif.q_pending[3:2] == 2'h0
      |=> r.sel_valid && r.sel_queue == 2'h1)
    else $error("strict queue 1 not ahead of queue 0");
  a_q0_served_last: assert property (
    r.sel_valid && r.sel_queue == 2'h0
      |-> $past(sif.q_pending[3:1] & ~ratio_on[3:1]) == 3'h0)
    else $error("queue 0 served ahead of strict higher queue");
  a_low_ratio_cap: assert property (
    ratio_on[0] && ratio_on[1] && r.allow[1:0] == 14'h0 && !sif.period_tick
      |=> !(r.sel_valid && r.sel_queue[1] == 1'b0))
    else $error("low queue sent with no allowance");
  a_period_reload: assert property (
    sif.period_tick && !sif.take |=> r.allow == $past(ratio_val))
    else $error("allowance not reloaded at period boundary");

endmodule

/* File: verif/tqs_sched_top_bench.sv */
// self-checking bench for the transmit queue ratio scheduler top
`timescale 1ns/10ps
module tqs_sched_top_bench
  import tqs_pkg::*;
;
  // ------------------------------------------------------------------
  // signals and instance
  // ------------------------------------------------------------------
  logic clk;
  logic reset_n;
  logic [11:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [1:0] reg_be;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [1:0][3:0] q_pending;
  logic [1:0] take;
  logic [1:0] sel_valid;
  logic [1:0][1:0] sel_queue;
  int err_total;
  int check_count;
  int cyc;
  int n;

  tqs_sched_top tqs_sched_top_i (
    .clk(clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_be(reg_be),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .q_pending(q_pending),
    .take(take),
    .sel_valid(sel_valid),
    .sel_queue(sel_queue)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // cycles since reset release, used to place the period boundary
  always @(posedge clk) begin
    cyc <= reset_n ? cyc + 1 : 0;
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic final_report();
    if (err_total == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // a strobe stays up across back-to-back accesses; bus_idle drops both
  task automatic wr_reg(input logic [11:0] a, input logic [1:0] be, input logic [15:0] d);
    reg_rd = 1'b0;
    reg_addr = a;
    reg_be = be;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
  endtask

  // read data is registered by the sampling edge, so it is compared just after it
  task automatic rd_reg(input logic [11:0] a, input logic [15:0] exp);
    reg_wr = 1'b0;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic bus_idle();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // one packet: selection checked, take pulsed, then a spare cycle; the
  // selection registered at the take edge already reflects the charged allowance
  task automatic send(input int p, input logic [1:0] q);
    chk({15'h0000, sel_valid[p]}, 16'h0001);
    chk({14'h0000, sel_queue[p]}, {14'h0000, q});
    take[p] = 1'b1;
    @(posedge clk);
    #1;
    take[p] = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic burst(input int p, input logic [1:0] q, input int cnt);
    for (int i = 0; i < cnt; i++) begin
      send(p, q);
    end
  endtask

  task automatic set_pend(input int p, input logic [3:0] v);
    q_pending[p] = v;
    @(posedge clk);
    #1;
  endtask

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    err_total = 0;
    check_count = 0;
    reset_n = 1'b0;
    reg_addr = 12'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_be = 2'h0;
    reg_wdata = 16'h0000;
    q_pending = '0;
    take = 2'h0;
    repeat (20) @(posedge clk);
    #1;
    reset_n = 1'b1;
    // port 2 in its reset ratio mode: 8,4,2,1 packets then hold
    set_pend(0, 4'hf);
    burst(0, 2'h3, 8);
    burst(0, 2'h2, 4);
    burst(0, 2'h1, 2);
    burst(0, 2'h0, 1);
    chk({15'h0000, sel_valid[0]}, 16'h0000);
    // register reset values, unmapped and byte-lane accesses
    rd_reg(TQS_P2_HI_OFS, 16'h8488);
    rd_reg(TQS_P2_LO_OFS, 16'h8182);
    rd_reg(TQS_P3_HI_OFS, 16'h8488);
    rd_reg(TQS_P3_LO_OFS, 16'h8182);
    rd_reg(12'h0d4, 16'h0000);
    wr_reg(TQS_P3_HI_OFS, 2'h3, 16'h0000);
    wr_reg(12'h0d3, 2'h3, 16'h0000);
    wr_reg(12'h0d4, 2'h3, 16'hffff);
    rd_reg(TQS_P3_HI_OFS, 16'h0000);
    rd_reg(TQS_P3_LO_OFS, 16'h0000);
    rd_reg(TQS_P2_HI_OFS, 16'h8488);
    rd_reg(TQS_P2_LO_OFS, 16'h8182);
    rd_reg(12'h0d4, 16'h0000);
    wr_reg(TQS_P2_LO_OFS, 2'h2, 16'h7f55);
    rd_reg(TQS_P2_LO_OFS, 16'h7f82);
    wr_reg(TQS_P2_LO_OFS, 2'h1, 16'h3355);
    rd_reg(TQS_P2_LO_OFS, 16'h7f55);
    wr_reg(TQS_P2_HI_OFS, 2'h3, 16'h1234);
    rd_reg(TQS_P2_HI_OFS, 16'h1234);
    wr_reg(TQS_P2_HI_OFS, 2'h3, 16'h8488);
    wr_reg(TQS_P2_LO_OFS, 2'h3, 16'h8182);
    bus_idle();
    // port 3 all strict: each queue goes past its reset ratio
    set_pend(1, 4'hf);
    burst(1, 2'h3, 12);
    set_pend(1, 4'h7);
    burst(1, 2'h2, 6);
    set_pend(1, 4'h3);
    burst(1, 2'h1, 4);
    set_pend(1, 4'h1);
    burst(1, 2'h0, 3);
    set_pend(1, 4'h0);
    // port 2 stays held until the period boundary reloads its allowances
    n = 0;
    while (sel_valid[0] !== 1'b1 && n < 2200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(cyc), 16'(TQS_PERIOD_CYC + 1));
    burst(0, 2'h3, 8);
    burst(0, 2'h2, 1);
    final_report();
  end

  // a hang past several periods' worth of cycles ends the run
  initial begin
    #50000;
    err_total++;
    final_report();
  end
endmodule
